// ### core/lcd_cmd_pkg.sv
// constants and types shared by both ends of the command link
package lcd_cmd_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SER_LAST = 7;
  // command patterns
  localparam logic [7:0] CMD_DISP_MASK = 8'hFE;
  localparam logic [7:0] CMD_DISP_VAL = 8'hAE;
  localparam logic [7:0] CMD_START_MASK = 8'hC0;
  localparam logic [7:0] CMD_START_VAL = 8'h40;
  localparam logic [7:0] CMD_PAGE_MASK = 8'hF0;
  localparam logic [7:0] CMD_PAGE_VAL = 8'hB0;
  localparam logic [7:0] CMD_ADC_MASK = 8'hFE;
  localparam logic [7:0] CMD_ADC_VAL = 8'hA0;
  localparam logic [7:0] CMD_ALLON_MASK = 8'hFE;
  localparam logic [7:0] CMD_ALLON_VAL = 8'hA4;
  localparam logic [7:0] CMD_BIAS_MASK = 8'hFE;
  localparam logic [7:0] CMD_BIAS_VAL = 8'hA2;
  localparam logic [7:0] CMD_POWER_MASK = 8'hF8;
  localparam logic [7:0] CMD_POWER_VAL = 8'h28;
  localparam logic [7:0] CMD_RES_MASK = 8'hF8;
  localparam logic [7:0] CMD_RES_VAL = 8'h20;
  localparam logic [7:0] CMD_COM_MASK = 8'hF0;
  localparam logic [7:0] CMD_COM_VAL = 8'hC0;
  localparam logic [7:0] CMD_VOL_MODE = 8'h81;
  localparam logic [7:0] CMD_RESET = 8'hE2;
  localparam logic [3:0] PAGE_MAX = 4'h8;
  // reset values
  localparam logic [5:0] VOL_RST = 6'h20;
  localparam logic [2:0] RES_RST = 3'h0;
  localparam logic [2:0] PWR_RST = 3'h0;
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [1:0] STATIC_RST = 2'h0;
  // host register map on wishbone
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DISP = 4'h8;
  localparam int unsigned STROBE_CYC = 2;
  typedef enum logic [1:0] {BUS_SEP, BUS_SHARED, BUS_SERIAL} bus_mode_t;
endpackage

// ### core/lcd_link_if.sv
// pin-level link between host and lcd command decoder
interface lcd_link_if;
  logic cmd_data_select;
  logic rd_n;
  logic wr_n;
  logic rw;
  logic en;
  logic [7:0] data;
  logic ser_clk;
  logic ser_data;
  logic ser_cs_n;
  modport device (input cmd_data_select, rd_n, wr_n, rw, en, data,
    ser_clk, ser_data, ser_cs_n);
  modport host (output cmd_data_select, rd_n, wr_n, rw, en, data,
    ser_clk, ser_data, ser_cs_n);
endinterface

// ### core/lcd_command_reset_decoder.sv
// lcd controller command decode and reset defaults
// Notes on behaviour
// RL1: low hard reset input resets everything
// RL2: reset: display off, normal direction, power zero
// RL3: reset: rmw off, save off, outputs ground
// RL4: reset: start line, column, page zero
// RL5: reset: resistance 000, volume 100000
// RL6: reset: test off, all-on cleared
// RL7: reset command applies only partial defaults
// RL8: access classified by select and strobes
// RL9: separate mode: low read/write pulses
// RL10: shared mode: direction level, high enable
// RL11: serial bytes arrive msb first
// RL12: 1010111x sets display on or off
// RL13: display off grounds all driver outputs
// RL14: all-on while off enters power save
// RL15: 01xxxxxx loads six-bit start line
// RL16: 1011xxxx loads page address up to 8
// RL17: page change touches only host access
// RL18: host enters power save before power down
// RL19: drive power select picks amp power
// RL20: power bits: booster, regulator, follower
// RL21: volume register maps inversely to step
// RL22: unknown command bytes are ignored
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
module lcd_command_reset_decoder (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic hard_reset_n,
  input wire lcd_cmd_pkg::bus_mode_t bus_mode,
  input wire logic drive_power_select,
  lcd_link_if.device link,
  output logic display_on,
  output logic drivers_grounded,
  output logic power_save,
  output logic all_on,
  output logic seg_reverse,
  output logic com_reverse,
  output logic bias_seventh,
  output logic rmw_on,
  output logic test_mode,
  output logic [1:0] static_ind,
  output logic [5:0] start_line,
  output logic [3:0] page_addr,
  output logic [7:0] column_addr,
  output logic [2:0] power_ctrl,
  output logic [2:0] res_factor,
  output logic [5:0] volume_reg,
  output logic [5:0] volume_step,
  output logic booster_on,
  output logic regulator_on,
  output logic follower_on,
  output logic amp_low_power,
  output logic [7:0] data_byte,
  output logic data_valid
);
  import lcd_cmd_pkg::*;

  typedef struct packed {
    logic disp;
    logic save;
    logic allon;
    logic segrev;
    logic comrev;
    logic bias7;
    logic rmw;
    logic test;
    logic [1:0] stat;
    logic [5:0] start;
    logic [3:0] page;
    logic [7:0] col;
    logic [2:0] pwr;
    logic [2:0] res;
    logic [5:0] vol;
    logic vol_wait;
    logic strobe_d;
    logic sclk_d;
    logic [7:0] shift;
    logic [2:0] bits;
    logic [7:0] dbyte;
    logic dvalid;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic hit(input logic [7:0] b, input logic [7:0] m,
                               input logic [7:0] v);
    hit = (b & m) == v;
  endfunction

  logic strobe_now, write_edge, is_data, got, ser_edge;
  logic [7:0] byte_in, ser_byte;

  always_comb begin
    // write strobe level per bus style
    strobe_now = 1'b0;
    case (bus_mode)
      BUS_SEP: strobe_now = !link.wr_n && link.rd_n; // RL8 RL9
      BUS_SHARED: strobe_now = link.en && !link.rw; // RL8 RL10
      default: strobe_now = 1'b0;
    endcase
    // commit on trailing edge so data is stable for whole pulse
    write_edge = s_r.strobe_d && !strobe_now;
    ser_edge = bus_mode == BUS_SERIAL && !link.ser_cs_n && link.ser_clk &&
               !s_r.sclk_d;
    ser_byte = {s_r.shift[6:0], link.ser_data}; // RL11
    got = write_edge || (ser_edge && s_r.bits == 3'(SER_LAST));
    byte_in = write_edge ? link.data : ser_byte;
    is_data = link.cmd_data_select; // RL8
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.dvalid = 1'b0;
    s_nxt.strobe_d = strobe_now;
    s_nxt.sclk_d = link.ser_clk;
    if (bus_mode != BUS_SERIAL || link.ser_cs_n) begin
      s_nxt.bits = 3'h0;
    end else if (ser_edge) begin
      s_nxt.shift = ser_byte; // RL11
      s_nxt.bits = s_r.bits + 3'h1;
    end
    if (got && is_data) begin
      s_nxt.dbyte = byte_in;
      s_nxt.dvalid = 1'b1;
    end else if (got && s_r.vol_wait) begin
      s_nxt.vol = byte_in[5:0];
      s_nxt.vol_wait = 1'b0;
    end else if (got) begin
      if (hit(byte_in, CMD_DISP_MASK, CMD_DISP_VAL)) begin
        s_nxt.disp = byte_in[0]; // RL12
        if (byte_in[0]) begin
          s_nxt.save = 1'b0;
        end
      end else if (hit(byte_in, CMD_START_MASK, CMD_START_VAL)) begin
        s_nxt.start = byte_in[5:0]; // RL15
      end else if (hit(byte_in, CMD_PAGE_MASK, CMD_PAGE_VAL)) begin
        // only host-side page pointer moves, display untouched
        if (byte_in[3:0] <= PAGE_MAX) begin
          s_nxt.page = byte_in[3:0]; // RL16 RL17
        end
      end else if (hit(byte_in, CMD_ALLON_MASK, CMD_ALLON_VAL)) begin
        s_nxt.allon = byte_in[0];
        if (byte_in[0] && !s_r.disp) begin
          s_nxt.save = 1'b1; // RL14
        end else if (!byte_in[0]) begin
          s_nxt.save = 1'b0;
        end
      end else if (hit(byte_in, CMD_ADC_MASK, CMD_ADC_VAL)) begin
        s_nxt.segrev = byte_in[0];
      end else if (hit(byte_in, CMD_BIAS_MASK, CMD_BIAS_VAL)) begin
        s_nxt.bias7 = byte_in[0];
      end else if (hit(byte_in, CMD_POWER_MASK, CMD_POWER_VAL)) begin
        s_nxt.pwr = byte_in[2:0]; // RL20
      end else if (hit(byte_in, CMD_RES_MASK, CMD_RES_VAL)) begin
        s_nxt.res = byte_in[2:0];
      end else if (hit(byte_in, CMD_COM_MASK, CMD_COM_VAL)) begin
        s_nxt.comrev = byte_in[3];
      end else if (byte_in == CMD_VOL_MODE) begin
        s_nxt.vol_wait = 1'b1;
      end else if (byte_in == CMD_RESET) begin
        // partial defaults; segment direction, power, serial, bias kept
        s_nxt.disp = 1'b0; // RL7
        s_nxt.rmw = 1'b0; // RL7
        s_nxt.stat = STATIC_RST; // RL7
        s_nxt.start = START_RST; // RL7
        s_nxt.col = 8'h00; // RL7
        s_nxt.page = PAGE_RST; // RL7
        s_nxt.comrev = 1'b0; // RL7
        s_nxt.res = RES_RST; // RL7
        s_nxt.vol = VOL_RST; // RL7
        s_nxt.vol_wait = 1'b0; // RL7
        s_nxt.test = 1'b0; // RL7
        s_nxt.allon = 1'b0; // RL7
      end
      // other bytes fall through unchanged
      // RL22
    end
    if (!hard_reset_n) begin
      s_nxt = '0; // RL1
      s_nxt.vol = VOL_RST; // RL5
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0; // RL2 RL3 RL4 RL6
      s_r.vol <= VOL_RST; // RL5
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign display_on = s_r.disp;
  assign drivers_grounded = !s_r.disp; // RL13 RL3
  assign power_save = s_r.save;
  assign all_on = s_r.allon;
  assign seg_reverse = s_r.segrev;
  assign com_reverse = s_r.comrev;
  assign bias_seventh = s_r.bias7;
  assign rmw_on = s_r.rmw;
  assign test_mode = s_r.test;
  assign static_ind = s_r.stat;
  assign start_line = s_r.start;
  assign page_addr = s_r.page;
  assign column_addr = s_r.col;
  assign power_ctrl = s_r.pwr;
  assign res_factor = s_r.res;
  assign volume_reg = s_r.vol;
  assign volume_step = ~s_r.vol; // RL21
  assign booster_on = s_r.pwr[2]; // RL20
  assign regulator_on = s_r.pwr[1]; // RL20
  assign follower_on = s_r.pwr[0]; // RL20
  assign amp_low_power = drive_power_select; // RL19
  assign data_byte = s_r.dbyte;
  assign data_valid = s_r.dvalid;
endmodule

// ### core/lcd_host_port.sv
// host end: wishbone registers driving the lcd command link
module lcd_host_port (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  lcd_link_if.host link
);
  import lcd_cmd_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_PULSE, H_HOLD} hstate_t;

  typedef struct packed {
    hstate_t st;
    logic [1:0] mode;
    logic a0;
    logic [7:0] byte_q;
    logic [2:0] bit_i;
    logic [1:0] cnt;
    logic sclk;
    logic act;
    logic ack;
    logic [31:0] rdat;
  } hstate_s_t;

  hstate_s_t h_r, h_nxt;
  logic req;

  always_comb begin
    h_nxt = h_r;
    h_nxt.ack = 1'b0;
    req = wb_cyc_i && wb_stb_i && !h_r.ack;
    if (req) begin
      h_nxt.ack = 1'b1;
      h_nxt.rdat = 32'h0000_0000;
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            h_nxt.mode = wb_dat_i[1:0];
          end
          h_nxt.rdat = {30'h0, h_r.mode};
        end
        REG_STATUS: h_nxt.rdat = {31'h0, h_r.st != H_IDLE};
        REG_DISP: begin
          // writes while busy are dropped; poll status first
          if (wb_we_i && wb_sel_i[0] && h_r.st == H_IDLE) begin
            h_nxt.byte_q = wb_dat_i[7:0];
            h_nxt.a0 = wb_dat_i[8];
            h_nxt.st = H_SETUP;
            h_nxt.cnt = 2'h0;
            h_nxt.bit_i = 3'h0;
          end
        end
        default: h_nxt.rdat = 32'h0000_0000;
      endcase
    end
    case (h_r.st)
      H_IDLE: h_nxt.act = 1'b0;
      H_SETUP: begin
        h_nxt.st = H_PULSE;
        h_nxt.act = 1'b1;
        h_nxt.sclk = 1'b0;
      end
      H_PULSE: begin
        h_nxt.cnt = h_r.cnt + 2'h1;
        if (h_r.mode == 2'(BUS_SERIAL)) begin
          h_nxt.sclk = !h_r.sclk;
          if (h_r.sclk) begin
            h_nxt.byte_q = {h_r.byte_q[6:0], 1'b0}; // RL11
            h_nxt.bit_i = h_r.bit_i + 3'h1;
            if (h_r.bit_i == 3'(SER_LAST)) begin
              h_nxt.st = H_HOLD;
            end
          end
        end else if (h_r.cnt == 2'(STROBE_CYC - 1)) begin
          h_nxt.act = 1'b0;
          h_nxt.st = H_HOLD;
        end
      end
      H_HOLD: begin
        h_nxt.act = 1'b0;
        h_nxt.st = H_IDLE;
      end
      default: h_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      h_r <= '0;
    end else if (clk_en) begin
      h_r <= h_nxt;
    end
  end

  logic ser;
  assign ser = h_r.mode == 2'(BUS_SERIAL);
  assign wb_ack_o = h_r.ack;
  assign wb_dat_o = h_r.rdat;
  assign link.cmd_data_select = h_r.a0;
  assign link.data = h_r.byte_q;
  assign link.wr_n = !(h_r.act && h_r.mode == 2'(BUS_SEP)); // RL9
  assign link.rd_n = 1'b1; // RL9
  assign link.rw = 1'b0; // RL10
  assign link.en = h_r.act && h_r.mode == 2'(BUS_SHARED); // RL10
  assign link.ser_clk = h_r.sclk;
  assign link.ser_data = h_r.byte_q[7]; // RL11
  assign link.ser_cs_n = !(ser && h_r.st != H_IDLE);
endmodule

// ### verif/lcd_link_chk.sv
// wire-level checks on the command link between host port and decoder
module lcd_link_chk
  import lcd_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire lcd_cmd_pkg::bus_mode_t bus_mode,
  input wire logic cmd_data_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic rw,
  input wire logic en,
  input wire logic [7:0] data,
  input wire logic ser_clk,
  input wire logic ser_cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rise_cnt_r;
  logic ser_clk_d_r;
  // counts serial clock rises inside one frame
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_cnt_r <= 4'h0;
      ser_clk_d_r <= 1'h0;
    end else begin
      ser_clk_d_r <= ser_clk;
      if (ser_cs_n) begin
        rise_cnt_r <= 4'h0;
      end else if (ser_clk && !ser_clk_d_r) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // reads are not offered, so the read strobe never pulses
  a_read_idle: assert property (rd_n)
    else $error("read strobe left idle level");
  a_wr_pulse: assert property ($fell(wr_n) |-> bus_mode == BUS_SEP
    ##1 !wr_n ##1 wr_n) else $error("write strobe pulse wrong");
  a_wr_hold: assert property ($fell(wr_n) |=>
    $stable(data) && $stable(cmd_data_select))
    else $error("byte moved under write strobe");
  a_en_pulse: assert property ($rose(en) |-> !rw &&
    bus_mode == BUS_SHARED ##1 en && !rw ##1 !en)
    else $error("enable pulse wrong");
  a_sep_no_en: assert property (bus_mode == BUS_SEP |-> !en)
    else $error("enable pulsed in separate mode");
  a_ser_count: assert property ($rose(ser_cs_n) |->
    rise_cnt_r == 4'h8) else $error("serial frame not eight clocks");
endmodule

// ### verif/testbench.sv
// self-checking bench: host port and decoder joined over the link
module testbench
  import lcd_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset_n = 0, hard_reset_n = 1, drive_power_select = 0;
  bus_mode_t bus_mode = BUS_SEP;
  logic cyc = 0, stb = 0, we = 0, ack, data_valid, amp, grd, psave, allon;
  logic disp, segr, comr, bias7, rmw, tst, bst, reg_on, fol;
  logic [3:0] adr = 4'h0, page;
  logic [31:0] wdat = 32'h0, rdat, rd_v, r;
  logic [1:0] stat;
  logic [5:0] start, vreg, vstep;
  logic [7:0] col, dbyte;
  logic [2:0] pwr, resf;
  logic [40:0] st;
  logic [3:0] pg;
  logic clk_en = 1;
  logic [7:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  localparam logic [40:0] RST = {2'h1, 9'h0, 6'h0, 4'h0, 8'h0, 6'h0, 6'h20};
  // segment direction, bias and power survive the command reset
  localparam logic [40:0] SOFT = RST | {4'h0, 3'h5, 22'h0, 3'h7, 9'h0};
  assign st = {disp, grd, psave, allon, segr, comr, bias7, rmw, tst, stat,
    start, page, col, pwr, resf, vreg};
  lcd_link_if link();
  lcd_host_port i_lcd_host_port (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(link));
  lcd_command_reset_decoder i_lcd_command_reset_decoder (.core_clk(core_clk),
    .reset_n(reset_n), .clk_en(clk_en), .hard_reset_n(hard_reset_n),
    .bus_mode(bus_mode), .drive_power_select(drive_power_select),
    .link(link), .display_on(disp), .drivers_grounded(grd),
    .power_save(psave), .all_on(allon), .seg_reverse(segr),
    .com_reverse(comr), .bias_seventh(bias7), .rmw_on(rmw), .test_mode(tst),
    .static_ind(stat), .start_line(start), .page_addr(page),
    .column_addr(col), .power_ctrl(pwr), .res_factor(resf),
    .volume_reg(vreg), .volume_step(vstep), .booster_on(bst),
    .regulator_on(reg_on), .follower_on(fol), .amp_low_power(amp),
    .data_byte(dbyte), .data_valid(data_valid));
  lcd_link_chk i_lcd_link_chk (.core_clk(core_clk), .reset_n(reset_n),
    .bus_mode(bus_mode), .cmd_data_select(link.cmd_data_select),
    .rd_n(link.rd_n), .wr_n(link.wr_n), .rw(link.rw), .en(link.en),
    .data(link.data), .ser_clk(link.ser_clk), .ser_cs_n(link.ser_cs_n));
  always #25 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [40:0] e,
    input logic [40:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // no fixed latency assumed: wait for ack, bench timeout ends a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'h1);
    rd_v = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic idle;
    do wb(1'h0, REG_STATUS, 32'h0); while (rd_v[0] !== 1'h0);
  endtask
  task automatic send(input logic a0, input logic [7:0] b);
    idle();
    wb(1'h1, REG_DISP, {23'h0, a0, b});
    if (a0) exp_q.push_back(b);
    repeat (24) @(posedge core_clk);
    idle();
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 30000) begin
      error_cnt++;
      complete_run();
    end
    if (data_valid === 1'h1) begin
      if (exp_q.size() == 0) chk("stray data", 41'h100, dbyte);
      else chk("data_byte", exp_q.pop_front(), dbyte);
    end
  end
  initial begin
    void'($urandom(51406));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
    chk("reset state", RST, st);
    for (int m = 0; m < 3; m++) begin
      bus_mode <= bus_mode_t'(m);
      wb(1'h1, REG_CTRL, m);
      r = $urandom;
      pg = (m == 0) ? 4'h8 : 4'(r[15:8] % 9);
      send(1'h0, 8'hAF);
      chk("on", 2'h2, {disp, grd});
      send(1'h0, {2'h1, r[5:0]});
      chk("start", r[5:0], start);
      send(1'h0, {4'hB, pg});
      chk("page", {1'h1, pg}, {disp, page});
      send(1'h1, r[23:16]);
      send(1'h0, 8'hB9);
      chk("bad page", pg, page);
      send(1'h0, 8'hAE);
      chk("off", 2'h1, {disp, grd});
      $display("test mode %0d done", m);
    end
    send(1'h0, 8'hA5);
    chk("save", 1'h1, psave);
    send(1'h0, 8'hAF);
    send(1'h0, {5'h5, r[26:24]});
    chk("power", {2{r[26:24]}}, {pwr, bst, reg_on, fol});
    send(1'h0, 8'h81);
    send(1'h0, {2'h0, r[31:26]});
    chk("volume", {r[31:26], ~r[31:26]}, {vreg, vstep});
    $display("test power done");
    // non-default power, directions, bias, all-on, start and page, then the partial reset
    send(1'h0, 8'h2F);
    send(1'h0, 8'hA1);
    send(1'h0, 8'hA3);
    send(1'h0, 8'hC8);
    send(1'h0, 8'hA5);
    send(1'h0, 8'h7F);
    send(1'h0, 8'hB3);
    send(1'h0, 8'hE2);
    chk("soft reset", SOFT, st);
    send(1'h0, 8'hFF);
    chk("unknown cmd", SOFT, st);
    drive_power_select <= r[0];
    @(posedge core_clk);
    chk("amp", r[0], amp);
    drive_power_select <= !r[0];
    @(posedge core_clk);
    chk("amp", !r[0], amp);
    // a hard reset held while frozen must wait for the enable
    clk_en <= 1'h0;
    hard_reset_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk("frozen", SOFT, st);
    clk_en <= 1'h1;
    @(posedge core_clk);
    hard_reset_n <= 1'h1;
    @(posedge core_clk);
    chk("hard reset", RST, st);
    $display("test reset done");
    complete_run();
  end
endmodule
